/* File: common/van_regs_pkg.sv */
/*
 * constants, field positions and carrier structs of the channel register bank
 * assumes one core clock; host bus pins are synchronous to it
 */
// Operation
// - write one clears flag, zero keeps it
// - clear bits map to the six flags
// - fourteen channel sets, eight bytes each
// - set base is 0x10 plus eight times n
// - resets never touch channel registers
// - 12-bit identifier plus four command bits
// - reception hit rewrites stored identifier
// - matching compares only the extension command bit
// - hit writes received command bits to buffer
// - invalid command/status setting makes channel inactive
// - pointer: ack suppress bit, 7-bit buffer offset
// - ack suppress blocks acknowledge, keeps interrupt
// - zero length turns pointer into link
// - only one level of linking followed
// - length field is data bytes plus one
// - device sets channel error; host clears
// - device sets tx/rx bits; host clears
// - mask bit one enables identifier bit compare
// - status flags readable at 0x09, same bits
package van_regs_pkg;
    localparam int          NUM_CHANNELS      = 14;
    localparam logic [7:0]  ADDR_INT_STATUS   = 8'h09;
    localparam logic [7:0]  ADDR_INT_CLEAR    = 8'h0B;
    localparam logic [7:0]  MAILBOX_BASE      = 8'h80;
    localparam logic [3:0]  CHAN_FIRST_SLOT   = 4'h2;
    localparam logic [7:0]  INT_STATUS_RESET  = 8'h80;
    localparam logic [7:0]  INT_RESERVED      = 8'h60;
    localparam logic [2:0]  OFS_ID_HIGH       = 3'h0;
    localparam logic [2:0]  OFS_ID_LOW_CMD    = 3'h1;
    localparam logic [2:0]  OFS_POINTER       = 3'h2;
    localparam logic [2:0]  OFS_LEN_STATUS    = 3'h3;
    localparam logic [2:0]  OFS_MASK_HIGH     = 3'h6;
    localparam logic [2:0]  OFS_MASK_LOW      = 3'h7;
    localparam logic [4:0]  LEN_LINKED        = 5'h00;
    localparam int          BIT_RESET_EVENT   = 7;
    localparam int          BIT_TX_FAULT      = 4;
    localparam int          BIT_TX_OK         = 3;
    localparam int          BIT_RX_FAULT      = 2;
    localparam int          BIT_RX_ACKED      = 1;
    localparam int          BIT_RX_UNACKED    = 0;

    // offset 1 low nibble, from bit 3 down
    typedef struct packed {
        logic compared_command_bit;
        logic ack_request;
        logic read_not_write;
        logic remote_transfer;
    } command_s;

    typedef struct packed {
        logic [11:0] frame_identifier;
        command_s    cmd;
        logic        ack_suppress_spy;
        logic [6:0]  buffer_offset;
        logic [4:0]  length;
        logic        channel_fault_abort;
        logic        channel_transmitted;
        logic        channel_received;
        logic [11:0] identifier_compare_mask;
    } chan_s;

    typedef struct packed {
        logic       cs;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] ad_in;
    } host_bus_s;

    typedef struct packed {
        logic        valid;
        logic [11:0] frame_identifier;
        command_s    cmd;
        logic [4:0]  rx_length;
    } match_req_s;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [3:0] channel;
        logic [7:0] buf_addr;
        logic [4:0] length;
        logic       ack_suppress;
    } match_rsp_s;

    typedef struct packed {
        logic       valid;
        logic [3:0] channel;
        logic       fault;
        logic       transmitted;
        logic       received;
    } stat_evt_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } mbox_wr_s;
endpackage : van_regs_pkg

/* File: rtl/van_channel_register_sets.sv */
/*
 * host-visible interrupt status/clear registers and fourteen channel
 * register sets, with identifier matching and single-level linking
 * assumes a frame engine beside it and a host on the multiplexed bus
 */
`timescale 1ns/1ps
`default_nettype none
module van_channel_register_sets (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire van_regs_pkg::host_bus_s  bus,
    output var  logic [7:0]               ad_out,
    output var  logic                     ad_oe,
    input  wire logic [7:0]               irq_event,
    output var  logic [7:0]               int_status,
    input  wire van_regs_pkg::match_req_s mreq,
    output var  van_regs_pkg::match_rsp_s mrsp,
    input  wire van_regs_pkg::stat_evt_s  stat,
    output var  van_regs_pkg::mbox_wr_s   mbox
);
    import van_regs_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic       cs_q;
        logic       wr_n_q;
        logic [7:0] wdata;
        logic [7:0] ad_out;
        logic       ad_oe;
        logic [7:0] int_status;
        match_rsp_s rsp;
        mbox_wr_s   mbox;
    } bank_state_s;

    bank_state_s st;
    bank_state_s next_st;
    // channel sets carry no reset on purpose: contents are random after power-up
    chan_s       chan [NUM_CHANNELS];

    logic                    wr_fire;
    logic                    rd_active;
    logic                    chan_sel;
    logic [3:0]              chan_idx;
    logic [2:0]              ofs;
    logic [7:0]              rd_data;
    logic [7:0]              clr_mask;
    logic [NUM_CHANNELS-1:0] hit;
    logic [NUM_CHANNELS-1:0] linked;
    logic [3:0]              eff [NUM_CHANNELS];
    logic                    any_hit;
    logic [3:0]              hit_chan;
    logic [3:0]              rx_target;

    // ==================================================================
    // host bus decode
    assign wr_fire   = st.cs_q && !st.wr_n_q && bus.wr_n;
    assign rd_active = bus.cs && !bus.rd_n;
    assign chan_sel  = !st.addr[7] && (st.addr[6:4] != 3'h0);
    assign chan_idx  = st.addr[6:3] - CHAN_FIRST_SLOT;
    assign ofs       = st.addr[2:0];
    assign clr_mask  = (wr_fire && st.addr == ADDR_INT_CLEAR) ? (st.wdata & ~INT_RESERVED) : 8'h00;

    always_comb begin
        rd_data = 8'h00;
        if (st.addr == ADDR_INT_STATUS) begin
            rd_data = st.int_status;
        end else if (chan_sel) begin
            case (ofs)
                OFS_ID_HIGH:    rd_data = chan[chan_idx].frame_identifier[11:4];
                OFS_ID_LOW_CMD: rd_data = {chan[chan_idx].frame_identifier[3:0], chan[chan_idx].cmd};
                OFS_POINTER:    rd_data = {chan[chan_idx].ack_suppress_spy, chan[chan_idx].buffer_offset};
                OFS_LEN_STATUS: rd_data = {chan[chan_idx].length, chan[chan_idx].channel_fault_abort,
                                           chan[chan_idx].channel_transmitted, chan[chan_idx].channel_received};
                OFS_MASK_HIGH:  rd_data = chan[chan_idx].identifier_compare_mask[11:4];
                OFS_MASK_LOW:   rd_data = {chan[chan_idx].identifier_compare_mask[3:0], 4'h0};
                default:        rd_data = 8'h00;
            endcase
        end
        // the clear register and all unmapped bytes fall through as zero
    end

    // ==================================================================
    // identifier matching and linking
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_match
            logic rx_state;
            logic tgt_ok;
            assign linked[gi] = chan[gi].length == LEN_LINKED;
            assign tgt_ok     = chan[gi].buffer_offset[3:0] < 4'(NUM_CHANNELS);
            // a link is followed once; the target's own length is not examined
            assign eff[gi]    = linked[gi] ? chan[gi].buffer_offset[3:0] : 4'(gi);
            // a link to a missing channel reads as already received, so it stays idle
            assign rx_state   = (linked[gi] && !tgt_ok) ? 1'b1 : chan[eff[gi]].channel_received;
            assign hit[gi]    = mreq.valid
                && !chan[gi].cmd.read_not_write && chan[gi].cmd.remote_transfer && !rx_state
                && (((chan[gi].frame_identifier ^ mreq.frame_identifier)
                     & chan[gi].identifier_compare_mask) == 12'h000)
                && (chan[gi].cmd.compared_command_bit == mreq.cmd.compared_command_bit);
        end
    endgenerate

    // lowest channel number wins when several sets match
    always_comb begin
        any_hit  = 1'b0;
        hit_chan = 4'h0;
        for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                any_hit  = 1'b1;
                hit_chan = 4'(i);
            end
        end
    end

    // the received bit lands on the channel that owns the buffer
    assign rx_target = (stat.channel < 4'(NUM_CHANNELS)) ? eff[stat.channel] : stat.channel;

    // ==================================================================
    // state update
    always_comb begin
        next_st        = st;
        next_st.cs_q   = bus.cs;
        next_st.wr_n_q = bus.wr_n;
        if (bus.ale) begin
            next_st.addr = bus.ad_in;
        end
        if (!bus.wr_n) begin
            next_st.wdata = bus.ad_in;
        end
        next_st.ad_oe  = rd_active;
        next_st.ad_out = rd_active ? rd_data : 8'h00;
        // or-ing events after the clear lets a fresh event survive
        next_st.int_status = ((st.int_status & ~clr_mask) | irq_event) & ~INT_RESERVED;
        next_st.rsp.valid        = mreq.valid;
        next_st.rsp.hit          = any_hit;
        next_st.rsp.channel      = hit_chan;
        next_st.rsp.buf_addr     = MAILBOX_BASE | {1'b0, chan[eff[hit_chan]].buffer_offset};
        next_st.rsp.length       = chan[eff[hit_chan]].length;
        // spy mode is the matched set's choice; the engine still reports rx ok
        next_st.rsp.ack_suppress = chan[hit_chan].ack_suppress_spy;
        next_st.mbox.valid       = any_hit;
        next_st.mbox.addr        = next_st.rsp.buf_addr;
        next_st.mbox.data        = {mreq.cmd.ack_request, mreq.cmd.read_not_write,
                                    mreq.cmd.remote_transfer, mreq.rx_length};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st            <= '0;
            st.wr_n_q     <= 1'b1;
            st.int_status <= INT_STATUS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================================
    // channel register sets
    generate
        for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
            logic host_wr;
            assign host_wr = wr_fire && chan_sel && chan_idx == 4'(gi);
            always_ff @(posedge core_clk) begin
                if (host_wr) begin
                    case (ofs)
                        OFS_ID_HIGH:    chan[gi].frame_identifier[11:4] <= st.wdata;
                        OFS_ID_LOW_CMD: {chan[gi].frame_identifier[3:0], chan[gi].cmd} <= st.wdata;
                        OFS_POINTER:    {chan[gi].ack_suppress_spy, chan[gi].buffer_offset} <= st.wdata;
                        OFS_LEN_STATUS: {chan[gi].length, chan[gi].channel_fault_abort,
                                         chan[gi].channel_transmitted, chan[gi].channel_received} <= st.wdata;
                        OFS_MASK_HIGH:  chan[gi].identifier_compare_mask[11:4] <= st.wdata;
                        OFS_MASK_LOW:   chan[gi].identifier_compare_mask[3:0] <= st.wdata[7:4];
                        default:        ;
                    endcase
                end
                if (any_hit && hit_chan == 4'(gi)) begin
                    chan[gi].frame_identifier <= mreq.frame_identifier;
                end
                // device sets come last so they beat a host write in the same cycle
                if (stat.valid && stat.fault && stat.channel == 4'(gi)) begin
                    chan[gi].channel_fault_abort <= 1'b1;
                end
                if (stat.valid && stat.transmitted && stat.channel == 4'(gi)) begin
                    chan[gi].channel_transmitted <= 1'b1;
                end
                if (stat.valid && stat.received && rx_target == 4'(gi)) begin
                    chan[gi].channel_received <= 1'b1;
                end
            end
        end
    endgenerate

    assign ad_out     = st.ad_out;
    assign ad_oe      = st.ad_oe;
    assign int_status = st.int_status;
    assign mrsp       = st.rsp;
    assign mbox       = st.mbox;

    // ==================================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_event_beats_clear;
        (irq_event != 8'h00) |=> ((st.int_status & $past(irq_event & ~INT_RESERVED))
                                  == $past(irq_event & ~INT_RESERVED));
    endproperty
    a_event_beats_clear: assert property (p_event_beats_clear) else $error("event lost to clear");

    property p_clear_one_bits;
        (wr_fire && st.addr == ADDR_INT_CLEAR && irq_event == 8'h00)
            |=> ((st.int_status & $past(st.wdata)) == 8'h00)
             && ((st.int_status & ~$past(st.wdata)) == ($past(st.int_status) & ~$past(st.wdata)));
    endproperty
    a_clear_one_bits: assert property (p_clear_one_bits) else $error("clear register misbehaved");

    property p_reserved_zero;
        (st.int_status & INT_RESERVED) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

    property p_clear_reads_zero;
        (rd_active && st.addr == ADDR_INT_CLEAR) |=> (ad_oe && ad_out == 8'h00);
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read nonzero");

    property p_id_high_read;
        (rd_active && chan_sel && ofs == OFS_ID_HIGH)
            |=> (ad_out == $past(chan[chan_idx].frame_identifier[11:4]));
    endproperty
    a_id_high_read: assert property (p_id_high_read) else $error("identifier read wrong");

    property p_hit_rewrites_id;
        any_hit |=> (chan[$past(hit_chan)].frame_identifier == $past(mreq.frame_identifier));
    endproperty
    a_hit_rewrites_id: assert property (p_hit_rewrites_id) else $error("identifier not rewritten");

    property p_hit_mailbox_byte;
        any_hit |=> (mbox.valid && mbox.data[7:5] == $past({mreq.cmd.ack_request,
                     mreq.cmd.read_not_write, mreq.cmd.remote_transfer}) && mbox.addr[7]);
    endproperty
    a_hit_mailbox_byte: assert property (p_hit_mailbox_byte) else $error("mailbox byte wrong");

    property p_link_length;
        (any_hit && linked[hit_chan]) |=> (mrsp.hit
            && mrsp.length == $past(chan[chan[hit_chan].buffer_offset[3:0]].length));
    endproperty
    a_link_length: assert property (p_link_length) else $error("link not followed");

    // engine-side answers, host bus reads and writes, and channel status sets, each one cycle after its cause
    property p_rsp_follows_req;
        mreq.valid |=> (mrsp.valid && mrsp.hit == $past(any_hit));
    endproperty
    a_rsp_follows_req: assert property (p_rsp_follows_req) else $error("match answer missing");

    property p_no_mbox_on_miss;
        (mreq.valid && !any_hit) |=> (!mbox.valid && !mrsp.hit);
    endproperty
    a_no_mbox_on_miss: assert property (p_no_mbox_on_miss) else $error("mailbox written on a miss");

    property p_buf_addr_in_mailbox;
        any_hit |=> (mrsp.buf_addr[7] && mbox.addr == mrsp.buf_addr && mrsp.channel == $past(hit_chan));
    endproperty
    a_buf_addr_in_mailbox: assert property (p_buf_addr_in_mailbox) else $error("buffer address wrong");

    property p_spy_from_matched;
        any_hit |=> (mrsp.ack_suppress == $past(chan[hit_chan].ack_suppress_spy));
    endproperty
    a_spy_from_matched: assert property (p_spy_from_matched) else $error("ack suppress wrong");

    property p_idle_bus_quiet;
        !rd_active |=> (!ad_oe && ad_out == 8'h00);
    endproperty
    a_idle_bus_quiet: assert property (p_idle_bus_quiet) else $error("bus driven while idle");

    property p_gap_offsets_zero;
        (rd_active && chan_sel && ofs[2] && !ofs[1]) |=> (ad_oe && ad_out == 8'h00);
    endproperty
    a_gap_offsets_zero: assert property (p_gap_offsets_zero) else $error("unused offset read nonzero");

    property p_status_read;
        (rd_active && st.addr == ADDR_INT_STATUS) |=> (ad_out == $past(st.int_status));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status register read wrong");

    property p_host_id_write;
        (wr_fire && chan_sel && ofs == OFS_ID_HIGH && !any_hit)
            |=> (chan[$past(chan_idx)].frame_identifier[11:4] == $past(st.wdata));
    endproperty
    a_host_id_write: assert property (p_host_id_write) else $error("identifier write lost");

    property p_fault_set;
        (stat.valid && stat.fault && stat.channel < 4'(NUM_CHANNELS))
            |=> chan[$past(stat.channel)].channel_fault_abort;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("channel fault not set");

    property p_received_set;
        (stat.valid && stat.received && rx_target < 4'(NUM_CHANNELS))
            |=> chan[$past(rx_target)].channel_received;
    endproperty
    a_received_set: assert property (p_received_set) else $error("received bit not set");

    c_hit:      cover property (any_hit ##1 mbox.valid);
    c_linked:   cover property (any_hit && linked[hit_chan]);
    c_clear:    cover property (wr_fire && st.addr == ADDR_INT_CLEAR);
    c_chan_rd:  cover property (rd_active && chan_sel);
    c_status:   cover property (stat.valid && stat.received);
endmodule : van_channel_register_sets
`default_nettype wire

/* File: sim/host_model.sv */
/*
 * host model on the multiplexed address/data bus of the channel register bank
 * assumes the bank drives ad_out/ad_oe one cycle after a read strobe, one core clock
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                    core_clk,
    input  wire logic [7:0]              ad_out,
    input  wire logic                    ad_oe,
    output var  van_regs_pkg::host_bus_s bus
);
    import van_regs_pkg::*;
    logic       cs_r    = 1'b0;
    logic       ale_r   = 1'b0;
    logic       rd_n_r  = 1'b1;
    logic       wr_n_r  = 1'b1;
    logic [7:0] host_ad = 8'h00;
    // a released pin shows the inverse of its last value, so stale data never looks valid
    always_comb bus = '{cs: cs_r, ale: ale_r, rd_n: rd_n_r, wr_n: wr_n_r, ad_in: ad_oe ? ad_out : host_ad};

    // ==========================================================
    // bus cycles
    task automatic addr_phase(input logic [7:0] addr);
        @(posedge core_clk);
        ale_r   <= 1'b1;
        cs_r    <= 1'b0;
        host_ad <= addr;
        @(posedge core_clk);
        ale_r   <= 1'b0;
        cs_r    <= 1'b1;
    endtask : addr_phase

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        addr_phase(addr);
        wr_n_r  <= 1'b0;
        host_ad <= (addr == ADDR_INT_CLEAR) ? (data & ~INT_RESERVED) : data;
        @(posedge core_clk);
        wr_n_r <= 1'b1;
        @(posedge core_clk);
        cs_r    <= 1'b0;
        host_ad <= ~host_ad;
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        addr_phase(addr);
        rd_n_r  <= 1'b0;
        host_ad <= ~host_ad;
        // hold the strobe until the edge that samples ad_oe high
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            if (ad_oe === 1'b1) break;
        end
        // a read that never drives the bus hands back unknown data, so the compare fails
        data = (ad_oe === 1'b1) ? ad_out : 'x;
        rd_n_r <= 1'b1;
        cs_r   <= 1'b0;
    endtask : rd
endmodule : host_model
`default_nettype wire

/* File: sim/test_van_channel_register_sets.sv */
/*
 * self-checking bench of the channel register bank: register map, flags, matching, linking
 * assumes host_model on the bus side; engine ports are driven here directly
 */
`timescale 1ns/1ps
`default_nettype none
module test_van_channel_register_sets;
    import van_regs_pkg::*;
    typedef struct packed { logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp; } row_s;
    localparam row_s ROWS [13] = '{'{8'h10, 8'hA5, 8'hA5}, '{8'h11, 8'h3C, 8'h3C}, '{8'h12, 8'h85, 8'h85},
        '{8'h13, 8'hFF, 8'hFF}, '{8'h16, 8'hF0, 8'hF0}, '{8'h17, 8'h9F, 8'h90}, '{8'h14, 8'hFF, 8'h00},
        '{8'h15, 8'hFF, 8'h00}, '{8'h78, 8'h5A, 8'h5A}, '{8'h7F, 8'h6E, 8'h60}, '{8'h0B, 8'h00, 8'h00},
        '{8'h09, 8'hFF, 8'h80}, '{8'h08, 8'hFF, 8'h00}};
    // ch1 receive with ack suppress, ch2 linked to ch3, ch4 linked to the already linked ch2
    localparam logic [15:0] SETUP [19] = '{16'h1812, 16'h1931, 16'h1A85, 16'h1EFF, 16'h1B18, 16'h2045,
        16'h2161, 16'h2203, 16'h2300, 16'h26FF, 16'h27F0, 16'h2A10, 16'h2B20,
        16'h3078, 16'h3191, 16'h3202, 16'h3300, 16'h36FF, 16'h37F0};
    logic       core_clk  = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] irq_event = 8'h00;
    match_req_s mreq      = '0;
    stat_evt_s  stat      = '0;
    host_bus_s  bus;
    logic [7:0] ad_out;
    logic       ad_oe;
    logic [7:0] int_status;
    match_rsp_s mrsp;
    mbox_wr_s   mbox;
    logic [7:0] rdata;
    logic [7:0] cur;
    int         miscompares = 0;
    int         cmp_count   = 0;

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    van_channel_register_sets dut (.core_clk(core_clk), .rst(rst), .bus(bus), .ad_out(ad_out), .ad_oe(ad_oe),
        .irq_event(irq_event), .int_status(int_status), .mreq(mreq), .mrsp(mrsp), .stat(stat), .mbox(mbox));
    host_model host (.core_clk(core_clk), .ad_out(ad_out), .ad_oe(ad_oe), .bus(bus));

    // ==========================================================
    // helpers
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        host.rd(addr, rdata);
        check($sformatf("reg %h", addr), rdata, exp);
    endtask : rd_chk

    task automatic match(input logic [11:0] id, input command_s cmd, input logic [4:0] len);
        @(posedge core_clk);
        mreq <= '{valid: 1'b1, frame_identifier: id, cmd: cmd, rx_length: len};
        @(posedge core_clk);
        mreq.valid <= 1'b0;
        #1;
    endtask : match

    task automatic stat_pulse(input logic [3:0] ch, input logic [2:0] ftr);
        @(posedge core_clk);
        stat <= {1'b1, ch, ftr};
        @(posedge core_clk);
        stat.valid <= 1'b0;
    endtask : stat_pulse

    // ==========================================================
    // watchdog: the sequence needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        #1 check("int_status", int_status, INT_STATUS_RESET);
        check("idle outputs", {ad_oe, mrsp, mbox}, '0);
        rd_chk(ADDR_INT_STATUS, INT_STATUS_RESET);
        for (int ch = 0; ch < NUM_CHANNELS; ch++)
            for (int o = 0; o < 8; o++)
                host.wr(8'(8'h10 + ch * 8 + o), (o == 3) ? 8'h03 : 8'h00);
        foreach (ROWS[i]) host.wr(ROWS[i].addr, ROWS[i].wdata);
        foreach (ROWS[i]) rd_chk(ROWS[i].addr, ROWS[i].exp);
        @(posedge core_clk) irq_event <= 8'hFF;
        @(posedge core_clk) irq_event <= 8'h00;
        #1 check("int_status", int_status, 8'h9F);
        cur = 8'h9F;
        for (int b = 0; b < 8; b++) begin
            if (cur[b]) begin
                host.wr(ADDR_INT_CLEAR, 8'(1 << b));
                cur[b] = 1'b0;
                rd_chk(ADDR_INT_STATUS, cur);
            end
        end
        // event lands on the very edge that executes the clear
        fork
            host.wr(ADDR_INT_CLEAR, 8'h08);
            begin
                repeat (3) @(posedge core_clk);
                irq_event <= 8'h08;
                @(posedge core_clk);
                irq_event <= 8'h00;
            end
        join
        #1 check("int_status", int_status, 8'h08);
        foreach (SETUP[i]) host.wr(SETUP[i][15:8], SETUP[i][7:0]);
        match(12'h12A, 4'b0101, 5'h02);
        check("rsp ch1", mrsp, {1'b1, 1'b1, 4'h1, 8'h85, 5'h03, 1'b1});
        check("mbox ch1", mbox, {1'b1, 8'h85, 8'hA2});
        rd_chk(8'h19, 8'hA1);
        match(12'h12A, 4'b1101, 5'h02);
        check("cmd bit miss", {mrsp.valid, mrsp.hit, mbox.valid}, 3'b100);
        match(12'h32A, 4'b0101, 5'h02);
        check("mask miss", {mrsp.valid, mrsp.hit, mbox.valid}, 3'b100);
        // ch3 has an all-zero mask and a clear received bit; only its transmit setting keeps it out
        match(12'hA53, 4'b0100, 5'h01);
        check("inactive miss", {mrsp.valid, mrsp.hit}, 2'b10);
        match(12'h456, 4'b0001, 5'h01);
        check("rsp link", mrsp, {1'b1, 1'b1, 4'h2, 8'h90, 5'h04, 1'b0});
        check("mbox link", mbox, {1'b1, 8'h90, 8'h21});
        match(12'h789, 4'b0001, 5'h01);
        check("rsp link of link", mrsp, {1'b1, 1'b1, 4'h4, 8'h83, 5'h00, 1'b0});
        stat_pulse(4'h2, 3'b001);
        stat_pulse(4'h1, 3'b110);
        rd_chk(8'h23, 8'h00);
        rd_chk(8'h2B, 8'h21);
        rd_chk(8'h1B, 8'h1E);
        match(12'h456, 4'b0001, 5'h01);
        check("received miss", {mrsp.valid, mrsp.hit}, 2'b10);
        // a second reset must leave every channel set alone
        @(posedge core_clk) rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1 check("int_status", int_status, INT_STATUS_RESET);
        rd_chk(8'h10, 8'hA5);
        rd_chk(8'h19, 8'hA1);
        end_sim();
    end
endmodule : test_van_channel_register_sets
`default_nettype wire
